//--- core/cdh_pkg.sv
// Package for the CPU debug halt control block
package cdh_pkg;

    // ----------------------------------------------------------------
    // Widths and addresses
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 32;
    localparam logic [31:0] CORE_WIN_LO = 32'hf7e10000;
    localparam logic [31:0] CORE_WIN_HI = 32'hf7e1ffff;
    localparam logic [31:0] PC_RESET    = 32'h00000000;
    localparam logic [31:0] CTX_PSW_OFF = 32'h00000004;
    localparam logic [31:0] LOOP_ONE    = 32'h00000001;
    localparam logic [31:0] ZERO32      = 32'h00000000;
    localparam logic [31:0] INSN_STEP   = 32'h00000004;

    // ----------------------------------------------------------------
    // Program status word field layout
    // ----------------------------------------------------------------
    localparam int unsigned PRS_W = 2;
    localparam int unsigned PRS_LSB = 12;
    localparam logic [PRS_W-1:0] PRS_RESET = 2'h0;

    // ----------------------------------------------------------------
    // Breakpoint actions, halt sources and controller states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_HALT = 2'h1,
        ACT_TRAP = 2'h2
    } cdh_action_t;

    typedef enum logic [2:0] {
        SRC_NONE  = 3'h0,
        SRC_WRITE = 3'h1,
        SRC_BKPT  = 3'h2,
        SRC_BREAK_INPUT_PIN = 3'h4
    } cdh_src_t;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_HALT = 3'b010,
        ST_MON  = 3'b100
    } cdh_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // One retiring instruction from the core pipeline
    typedef struct packed {
        logic              valid;
        logic [31:0]       pc;
        logic [31:0]       seqPc;       // Fall-through address
        logic              isBranch;    // Load-store pipe branch or loop
        logic              isLoop;
        logic              taken;       // Resolved outcome, never the prediction
        logic [31:0]       target;
        logic [31:0]       loopCount;
        logic              haltWrite;   // Write to debug_status_reg setting halt
        logic              injected;    // Came through debug_injection_port
        logic              isRfm;
        logic [31:0]       savedPsw;    // Status word read from context + 4
    } cdh_retire_t;

    typedef struct packed {
        logic              valid;
        logic [31:0]       addr;
        logic              write;
    } cdh_bus_t;

    typedef struct packed {
        cdh_state_t        state;
        logic [31:0]       pc;
        logic [PRS_W-1:0]  protection_set_select;
        logic [PRS_W-1:0]  monPrs;
        logic [31:0]       loopCount;
        logic              loopWrite;
        cdh_src_t          src;
        logic              halted;
        logic              trapEnter;
        logic              busConflict;
        logic              stepArmed;
    } cdh_state_s_t;

    function automatic logic inCoreWindow(input logic [31:0] a);
        return (a >= CORE_WIN_LO) && (a <= CORE_WIN_HI);
    endfunction

endpackage : cdh_pkg

//--- core/cdh_halt_ctrl.sv
// Debug halt, breakpoint, monitor return and loop exit control
//
// Contract
// RULE1: A halting write to the debug status register halts the CPU with the correct next address in the PC.
// RULE2: Injected and program-fetched halting writes behave the same way.
// RULE3: A branch or loop right after a halting write resolves first, so the PC never holds a mispredicted target.
// RULE4: The PC read while halted is the true next address, and execution resumes from it.
// RULE5: An external agent should stop the CPU through the break input or breakpoints, not injected writes.
// RULE6: Software should follow any write to the debug status register with a barrier.
// RULE7: A trap-action breakpoint enters the monitor, and return_from_monitor restores context and status word.
// RULE8: After return_from_monitor execution resumes where the breakpoint interrupted it.
// RULE9: The restored protection set governs every instruction fetched after the return, the very next included.
// RULE10: Monitor software should copy the saved protection set from context offset 4 and barrier before returning.
// RULE11: A halt-action after-execution breakpoint halts right after the instruction with a correct next PC.
// RULE12: For stepping the debugger sets two ranges that exclude only the current address; the agent's second range also stops at 32'h0fffffff.
// RULE13: With those ranges bound to halt-action before-execution breakpoints, one instruction runs and the CPU halts.
// RULE14: A loop with a zero count falls through and never wraps to all ones.
// RULE15: Bus accesses to the core register window while running do not disturb later loop exits.
// RULE16: External masters should reach the core register window only while halted.
// RULE17: The source that halted the CPU is recorded for the debugger.
`timescale 1ns/1ps
module cdh_halt_ctrl
    import cdh_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // Retiring instruction
    input  wire cdh_retire_t      retire,
    // Breakpoint matches on the retiring instruction
    input  wire logic             bbmHit,
    input  wire cdh_action_t      bbmAction,
    input  wire logic             bamHit,
    input  wire cdh_action_t      bamAction,
    // Debugger controls
    input  wire logic             breakIn,
    input  wire logic             wakeReq,
    // System bus observation
    input  wire cdh_bus_t         sysBus,
    // Status toward debugger and core
    output logic                  halted,
    output logic                  trapEnter,
    output logic [31:0]           pcOut,
    output logic [PRS_W-1:0]      prsOut,
    output logic [31:0]           loopCountOut,
    output logic                  loopWrite,
    output cdh_src_t              haltSrc,
    output logic                  busConflict
);

    cdh_state_s_t s_q;
    cdh_state_s_t s_d;

    // Next address after a retired instruction, from resolved outcome only
    function automatic logic [31:0] nextPc(input cdh_retire_t r, input logic loopTaken);
        if (r.isLoop) begin
            return loopTaken ? r.target : r.seqPc;
        end
        return (r.isBranch && r.taken) ? r.target : r.seqPc;
    endfunction

    logic        loopTaken;
    logic [31:0] npc;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.trapEnter = 1'b0;
        s_d.loopWrite = 1'b0;
        // Loop exits depend only on the operand, never on bus traffic
        loopTaken = retire.isLoop && (retire.loopCount != ZERO32); // RULE14 RULE15
        npc       = nextPc(retire, loopTaken); // RULE3
        // Flagged for the debugger only; it never feeds the loop path
        if (sysBus.valid && inCoreWindow(sysBus.addr) && !s_q.halted) begin
            s_d.busConflict = 1'b1; // RULE16
        end
        unique case (s_q.state)
            ST_RUN: begin
                if (breakIn) begin
                    s_d.state = ST_HALT;
                    s_d.src   = SRC_BREAK_INPUT_PIN; // RULE17
                end else if (retire.valid) begin
                    if (bbmHit && bbmAction == ACT_HALT) begin
                        // Instruction does not execute; PC stays on it
                        s_d.pc    = retire.pc; // RULE13
                        s_d.state = ST_HALT;
                        s_d.src   = SRC_BKPT;
                    end else if (bbmHit && bbmAction == ACT_TRAP) begin
                        s_d.pc     = retire.pc;
                        s_d.monPrs = s_q.protection_set_select;
                        s_d.state  = ST_MON; // RULE7
                        s_d.trapEnter = 1'b1;
                    end else begin
                        s_d.pc = npc; // RULE3
                        if (retire.isLoop) begin
                            s_d.loopCount = loopTaken ? retire.loopCount - LOOP_ONE : ZERO32; // RULE14
                            s_d.loopWrite = 1'b1;
                        end
                        if (retire.haltWrite) begin
                            // Same path for injected and fetched writes
                            s_d.state = ST_HALT; // RULE1 RULE2
                            s_d.src   = SRC_WRITE;
                        end else if (bamHit && bamAction == ACT_HALT) begin
                            s_d.state = ST_HALT; // RULE11
                            s_d.src   = SRC_BKPT;
                        end else if (bamHit && bamAction == ACT_TRAP) begin
                            s_d.monPrs    = s_q.protection_set_select;
                            s_d.state     = ST_MON; // RULE7
                            s_d.trapEnter = 1'b1;
                        end
                    end
                end
            end
            ST_HALT: begin
                if (wakeReq) begin
                    s_d.state = ST_RUN; // RULE4
                    s_d.src   = SRC_NONE;
                end
            end
            ST_MON: begin
                if (retire.valid && retire.isRfm) begin
                    // Protection set applies from the next fetch on
                    s_d.protection_set_select   = retire.savedPsw[PRS_LSB +: PRS_W]; // RULE9
                    s_d.state = ST_RUN; // RULE8
                end
            end
        endcase
        s_d.halted = (s_d.state == ST_HALT);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{state: ST_RUN, pc: PC_RESET, protection_set_select: PRS_RESET, monPrs: PRS_RESET,
                     loopCount: ZERO32, loopWrite: 1'b0, src: SRC_NONE, halted: 1'b0,
                     trapEnter: 1'b0, busConflict: 1'b0, stepArmed: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign halted       = s_q.halted;
    assign trapEnter    = s_q.trapEnter;
    assign pcOut        = s_q.pc;
    assign prsOut       = s_q.protection_set_select;
    assign loopCountOut = s_q.loopCount;
    assign loopWrite    = s_q.loopWrite;
    assign haltSrc      = s_q.src;
    assign busConflict  = s_q.busConflict;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_write_halts: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
        (s_q.state == ST_RUN && !breakIn && retire.valid && !bbmHit && retire.haltWrite)
        |=> halted && haltSrc == SRC_WRITE)
        else $error("halting write did not halt");
    a_halt_pc_resolved: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE3
        (s_q.state == ST_RUN && !breakIn && retire.valid && !bbmHit && retire.haltWrite
         && retire.isBranch && !retire.isLoop && !retire.taken) |=> pcOut == $past(retire.seqPc))
        else $error("halt left mispredicted target in pc");
    a_inject_same: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE2
        (s_q.state == ST_RUN && !breakIn && retire.valid && !bbmHit && retire.haltWrite && retire.injected)
        |=> halted)
        else $error("injected write behaved differently");
    a_halt_pc_stable: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE4
        halted && !wakeReq |=> $stable(pcOut))
        else $error("pc moved while halted");
    a_rfm_prs: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE9
        (s_q.state == ST_MON && retire.valid && retire.isRfm)
        |=> prsOut == $past(retire.savedPsw[PRS_LSB +: PRS_W]) && s_q.state == ST_RUN)
        else $error("protection set not restored at return");
    a_trap_enter: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE7
        (s_q.state == ST_RUN && !breakIn && retire.valid && bbmHit && bbmAction == ACT_TRAP)
        |=> trapEnter ##1 !trapEnter)
        else $error("trap breakpoint did not enter monitor");
    a_loop_zero_exit: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE14
        (s_q.state == ST_RUN && !breakIn && retire.valid && !bbmHit && retire.isLoop
         && retire.loopCount == ZERO32) |=> pcOut == $past(retire.seqPc) && loopCountOut == ZERO32)
        else $error("loop wrapped instead of falling through");
    a_break_input_pin_src: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE17
        (s_q.state == ST_RUN && breakIn) |=> halted && haltSrc == SRC_BREAK_INPUT_PIN)
        else $error("break input source not recorded");
    a_bam_halt: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE11
        (s_q.state == ST_RUN && !breakIn && retire.valid && !bbmHit && !retire.haltWrite
         && bamHit && bamAction == ACT_HALT) |=> halted && pcOut == $past(npc))
        else $error("after-execution halt pc wrong");
    a_step_halt: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE13
        (s_q.state == ST_RUN && !breakIn && retire.valid && bbmHit && bbmAction == ACT_HALT)
        |=> halted && pcOut == $past(retire.pc))
        else $error("before-execution halt did not stop on instruction");

endmodule // cdh_halt_ctrl

//--- bench/cdh_dbg_agent.sv
// Debug agent model that stops, wakes and polls the CPU
`timescale 1ns/1ps
module cdh_dbg_agent
    import cdh_pkg::*;
(
    // Clock and CPU status
    input  wire logic clk_sys,
    input  wire logic halted,
    // Requests toward the CPU
    output logic      breakIn,
    output logic      wakeReq,
    output cdh_bus_t  sysBus
);
    initial begin
        breakIn = 1'b0;
        wakeReq = 1'b0;
        sysBus  = '0;
    end
    // Stops through the break input, never by injected register writes
    task automatic stopCpu();
        breakIn = 1'b1;
        @(posedge clk_sys);
        #1 breakIn = 1'b0;
    endtask
    // A slow tool lets some cycles pass before it wakes the core
    task automatic wake(input int lag);
        repeat (lag) @(posedge clk_sys);
        #1 wakeReq = 1'b1;
        @(posedge clk_sys);
        #1 wakeReq = 1'b0;
    endtask
    // Window reached only while halted unless a test asks otherwise
    task automatic poke(input logic [31:0] a, input logic onRun);
        if (a < CORE_WIN_LO || a > CORE_WIN_HI || halted || onRun) begin
            sysBus = '{valid: 1'b1, addr: a, write: 1'b0};
            @(posedge clk_sys);
            #1 sysBus = '{valid: 1'b0, addr: ~a, write: 1'b1};
        end
    endtask
    // Two stepping ranges that leave out the current address and every address above 32'h0fffffff
    function automatic logic stepHit(input logic [31:0] pc, input logic [31:0] cur);
        return (pc < cur) || (pc > cur && pc <= 32'h0fffffff);
    endfunction
endmodule // cdh_dbg_agent

//--- bench/tb_top.sv
// Self-checking bench for the debug halt control block
`timescale 1ns/1ps
module tb_top;
    import cdh_pkg::*;
    logic clk_sys, arst_n, bbmHit, bamHit, breakIn, wakeReq;
    logic halted, trapEnter, loopWrite, busConflict;
    logic [31:0] pcOut, loopCountOut;
    logic [PRS_W-1:0] prsOut;
    cdh_retire_t retire;
    cdh_action_t bbmAction, bamAction;
    cdh_bus_t sysBus;
    cdh_src_t haltSrc;
    int miscompares, compares;

    cdh_halt_ctrl i_cdh_halt_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .retire(retire),
        .bbmHit(bbmHit), .bbmAction(bbmAction), .bamHit(bamHit), .bamAction(bamAction),
        .breakIn(breakIn), .wakeReq(wakeReq), .sysBus(sysBus), .halted(halted),
        .trapEnter(trapEnter), .pcOut(pcOut), .prsOut(prsOut), .loopCountOut(loopCountOut),
        .loopWrite(loopWrite), .haltSrc(haltSrc), .busConflict(busConflict));
    cdh_dbg_agent i_cdh_dbg_agent (.clk_sys(clk_sys), .halted(halted), .breakIn(breakIn),
        .wakeReq(wakeReq), .sysBus(sysBus));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chkBit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chkSrc(input cdh_src_t exp);
        chkWord("haltSrc", {29'h0, exp}, {29'h0, haltSrc});
    endtask
    // One edge takes the request; its answer is visible on return
    task automatic fire();
        @(posedge clk_sys);
        #1;
        retire = '0;
        bbmHit = 1'b0;
        bamHit = 1'b0;
    endtask
    task automatic insn(input logic [31:0] pc);
        retire       = '0;
        retire.valid = 1'b1;
        retire.pc    = pc;
        retire.seqPc = pc + INSN_STEP;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic haltByWrite(input logic inj);
        insn(32'h00000100);
        retire.haltWrite = 1'b1;
        retire.injected  = inj;
        fire();
        // Mispredicted branch right behind the halting write
        insn(32'h00000104);
        {retire.isBranch, retire.taken, retire.target} = {2'b11, 32'h00000800};
        chkBit("halted", 1'b1, halted);
        chkSrc(SRC_WRITE);
        fire();
        chkWord("pcOut", 32'h00000104, pcOut);
        i_cdh_dbg_agent.poke(CORE_WIN_LO, 1'b0);
        chkBit("busConflict", 1'b0, busConflict);
        i_cdh_dbg_agent.wake(1);
        chkBit("halted", 1'b0, halted);
        chkSrc(SRC_NONE);
        chkWord("pcOut", 32'h00000104, pcOut);
        // The barrier behind the halting write retires first once the core runs again
        insn(32'h00000104);
        fire();
        chkWord("pcOut", 32'h00000108, pcOut);
    endtask
    task automatic breakHalt();
        insn(32'h00000200);
        i_cdh_dbg_agent.stopCpu();
        retire = '0;
        chkBit("halted", 1'b1, halted);
        chkSrc(SRC_BREAK_INPUT_PIN);
        i_cdh_dbg_agent.wake(3);
    endtask
    task automatic singleStep();
        insn(32'h00000300);
        {bbmHit, bbmAction} = {1'b1, ACT_HALT};
        fire();
        chkWord("pcOut", 32'h00000300, pcOut);
        chkSrc(SRC_BKPT);
        i_cdh_dbg_agent.wake(0);
        for (int i = 0; i < 2; i++) begin
            insn(32'h00000300 + 32'(i * 4));
            bbmHit = i_cdh_dbg_agent.stepHit(retire.pc, 32'h00000300);
            fire();
        end
        chkBit("halted", 1'b1, halted);
        chkWord("pcOut", 32'h00000304, pcOut);
        i_cdh_dbg_agent.wake(0);
    endtask
    task automatic trapReturn();
        insn(32'h00000400);
        {bbmHit, bbmAction} = {1'b1, ACT_TRAP};
        fire();
        chkBit("trapEnter", 1'b1, trapEnter);
        insn(32'h00000900);
        fire();
        chkBit("trapEnter", 1'b0, trapEnter);
        insn(32'h00000904);
        retire.isRfm = 1'b1;
        // Monitor copied the saved status word from context plus 4
        retire.savedPsw = 32'h00002000;
        fire();
        chkWord("prsOut", 32'h2, 32'(prsOut));
        insn(32'h00000400);
        fire();
        chkWord("pcOut", 32'h00000404, pcOut);
        chkWord("prsOut", 32'h2, 32'(prsOut));
    endtask
    task automatic bamJump(input logic tk);
        insn(32'h00000500);
        {retire.isBranch, retire.taken, retire.target} = {1'b1, tk, 32'h000005f0};
        {bamHit, bamAction} = {1'b1, ACT_HALT};
        fire();
        chkBit("halted", 1'b1, halted);
        chkWord("pcOut", tk ? 32'h000005f0 : 32'h00000504, pcOut);
        i_cdh_dbg_agent.wake(0);
    endtask
    task automatic loopOnce(input logic [31:0] cnt);
        insn(32'h00000600);
        {retire.isBranch, retire.isLoop, retire.taken} = {2'b11, cnt != ZERO32};
        {retire.target, retire.loopCount} = {32'h000005c0, cnt};
        fire();
        chkBit("loopWrite", 1'b1, loopWrite);
        chkWord("loopCount", cnt == ZERO32 ? ZERO32 : cnt - LOOP_ONE, loopCountOut);
        chkWord("pcOut", cnt == ZERO32 ? 32'h00000604 : 32'h000005c0, pcOut);
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        complete_run();
    end
    initial begin
        {retire, bbmHit, bamHit, arst_n} = '0;
        {bbmAction, bamAction} = {ACT_NONE, ACT_NONE};
        {miscompares, compares} = '0;
        repeat (6) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 2; i++) haltByWrite(i[0]);
        breakHalt();
        singleStep();
        trapReturn();
        for (int i = 0; i < 2; i++) bamJump(i[0]);
        loopOnce(32'h1);
        loopOnce(ZERO32);
        i_cdh_dbg_agent.poke(32'hf7e20000, 1'b1);
        chkBit("busConflict", 1'b0, busConflict);
        i_cdh_dbg_agent.poke(CORE_WIN_HI, 1'b1);
        chkBit("busConflict", 1'b1, busConflict);
        loopOnce(ZERO32);
        complete_run();
    end
endmodule // tb_top
